// *** uad_byte_src.sv ***
`default_nettype none
// Record source: offers queued bytes and holds each one until it is taken
module uad_byte_src (
    input  wire logic clk_in,
    input  wire logic ready_in,
    input  wire logic stall_in,
    output logic [7:0] byte_out,
    output logic       valid_out,
    output logic       last_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] q[$];
    logic       took;
    logic       st;
    initial
    begin
        valid_out = 1'b0;
        byte_out  = 8'h00;
        last_out  = 1'b0;
    end
    // Padding and one coding per record come from the queued data
    always @(posedge clk_in)
    begin
        took = valid_out && ready_in;
        st   = stall_in;
        if (took)
            q.delete(0);
        #1;
        if (took || !valid_out)
        begin
            if (q.size() > 0 && !st)
            begin
                valid_out = 1'b1;
                {last_out, byte_out} = q[0];
            end
            else
            begin
                valid_out = 1'b0;
                byte_out  = ~byte_out; // Released lines toggle every idle clock rather than hold the stale byte
                last_out  = ~last_out;
            end
        end
    end
endmodule
`default_nettype wire

// *** uad_decoder.sv ***
`default_nettype none
module uad_decoder (
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic [7:0]  byte_in,
    input  wire logic        byte_valid_in,
    input  wire logic        byte_last_in,
    output logic             byte_ready_out,
    output logic [15:0]      cp_out,
    output logic             cp_valid_out,
    input  wire logic        cp_ready_in,
    output logic             done_out
);
    uad_pkg::uad_state_e state_q;
    uad_pkg::uad_state_e state_d;
    logic [7:0]          left_q;
    logic [7:0]          left_d;
    logic [15:0]         base_q;
    logic [15:0]         base_d;
    logic [7:0]          hi_q;
    logic                half_q;
    logic                done_q;

    wire                 buf_ready;
    wire                 take;
    wire                 hdr_end;
    wire                 count_hit;
    wire                 is_pairs;
    wire                 is_half8;
    wire                 is_half16;
    wire                 top_set;
    wire  [15:0]         dflt_cp;
    wire  [15:0]         offset_cp;
    wire  [15:0]         pair_cp;
    wire  [15:0]         half_base;
    wire                 emit_pair;
    wire                 emit_plain;
    wire                 emit_char;
    wire                 emit;
    wire  [15:0]         emit_data;
    wire                 done_d;

    // Byte acceptance follows the buffer, so a stalled receiver stalls the source
    assign buf_ready      = byte_ready_out;
    assign take           = byte_valid_in && buf_ready;

    // Leading byte decode
    assign is_pairs       = (byte_in == uad_pkg::LEAD_PAIRS);
    assign is_half8       = (byte_in == uad_pkg::LEAD_HALF8);
    assign is_half16      = (byte_in == uad_pkg::LEAD_HALF16);

    // Character candidates
    assign top_set        = byte_in[uad_pkg::SEL_BIT];
    assign dflt_cp        = {9'h000, byte_in[6:0]};
    assign offset_cp      = base_q + {9'h000, byte_in[6:0]};
    assign pair_cp        = {hi_q, byte_in};
    assign half_base      = {1'b0, byte_in, 7'h00};

    // Emission decode; FF pairs and FF pass bytes are padding
    assign emit_pair      = (state_q == uad_pkg::UAD_PAIR_LO) && (pair_cp != uad_pkg::PAD_PAIR);
    assign emit_plain     = ((state_q == uad_pkg::UAD_PASS)
                            || ((state_q == uad_pkg::UAD_IDLE) && !is_pairs && !is_half8
                                && !is_half16))
                            && (byte_in != uad_pkg::PAD_BYTE);
    assign emit_char      = (state_q == uad_pkg::UAD_CHARS);
    assign emit           = take && (emit_pair || emit_plain || emit_char);
    assign emit_data      = emit_pair ? pair_cp :
                            (emit_char && top_set) ? offset_cp : dflt_cp;

    // Count bookkeeping for the counted schemes
    assign hdr_end        = ((state_q == uad_pkg::UAD_BASE_HI) && half_q)
                            || (state_q == uad_pkg::UAD_BASE_LO);
    assign count_hit      = (hdr_end && (left_q == 8'h00))
                            || (emit_char && (left_q == 8'h01));
    assign done_d         = take && (count_hit
                            || (byte_last_in && (state_q != uad_pkg::UAD_DRAIN)));
    assign done_out       = done_q;

    // Next state: last byte ends the record, reaching the count drains the rest
    always_comb
    begin
        state_d = state_q;
        if (take)
        begin
            if (byte_last_in)
                state_d = uad_pkg::UAD_IDLE;
            else if (count_hit)
                state_d = uad_pkg::UAD_DRAIN;
            else
            begin
                unique case (state_q)
                    uad_pkg::UAD_IDLE:
                    begin
                        if (is_pairs)
                            state_d = uad_pkg::UAD_PAIR_HI;
                        else if (is_half8 || is_half16)
                            state_d = uad_pkg::UAD_COUNT;
                        else
                            state_d = uad_pkg::UAD_PASS;
                    end
                    uad_pkg::UAD_COUNT:   state_d = uad_pkg::UAD_BASE_HI;
                    uad_pkg::UAD_BASE_HI: state_d = half_q ? uad_pkg::UAD_CHARS
                                                           : uad_pkg::UAD_BASE_LO;
                    uad_pkg::UAD_BASE_LO: state_d = uad_pkg::UAD_CHARS;
                    uad_pkg::UAD_CHARS:   state_d = uad_pkg::UAD_CHARS;
                    uad_pkg::UAD_PAIR_HI: state_d = uad_pkg::UAD_PAIR_LO;
                    uad_pkg::UAD_PAIR_LO: state_d = uad_pkg::UAD_PAIR_HI;
                    uad_pkg::UAD_PASS:    state_d = uad_pkg::UAD_PASS;
                    uad_pkg::UAD_DRAIN:   state_d = uad_pkg::UAD_DRAIN;
                    default:              state_d = uad_pkg::UAD_IDLE;
                endcase
            end
        end
    end

    // Count and base pointer capture
    always_comb
    begin
        left_d = left_q;
        base_d = base_q;
        if (take && (state_q == uad_pkg::UAD_COUNT))
            left_d = byte_in;
        if (take && emit_char)
            left_d = left_q - 8'h01;
        if (take && (state_q == uad_pkg::UAD_BASE_HI))
            base_d = half_q ? half_base : {byte_in, 8'h00};
        if (take && (state_q == uad_pkg::UAD_BASE_LO))
            base_d = {base_q[15:8], byte_in};
    end

    // State registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            state_q <= uad_pkg::UAD_IDLE;
            left_q  <= uad_pkg::COUNT_RST;
            base_q  <= uad_pkg::BASE_RST;
            hi_q    <= uad_pkg::HI_RST;
            half_q  <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            left_q  <= left_d;
            base_q  <= base_d;
            done_q  <= done_d;
            if (take && (state_q == uad_pkg::UAD_PAIR_HI))
                hi_q <= byte_in;
            if (take && (state_q == uad_pkg::UAD_IDLE))
                half_q <= is_half8;
        end
    end

    // Two-entry buffer between the decoder and the display side
    uad_skid_buf #(
        .WIDTH (uad_pkg::CP_W),
        .DEPTH (uad_pkg::BUF_DEPTH)
    ) u_buf (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .in_valid_in   (emit),
        .in_ready_out  (byte_ready_out),
        .in_data_in    (emit_data),
        .out_valid_out (cp_valid_out),
        .out_ready_in  (cp_ready_in),
        .out_data_out  (cp_out)
    );

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_pair_scheme_entry: assert property (
        take && (state_q == uad_pkg::UAD_IDLE) && is_pairs && !byte_last_in
        |=> (state_q == uad_pkg::UAD_PAIR_HI))
        else $error("Leading 80 did not enter pair decoding");
    a_pair_msb_first: assert property (
        take && (state_q == uad_pkg::UAD_PAIR_HI) && !byte_last_in ##1
        take && (state_q == uad_pkg::UAD_PAIR_LO)
        |-> (pair_cp == uad_pkg::PAD_PAIR)
            || (emit && (emit_data == {$past(byte_in), byte_in})))
        else $error("Pair high byte not taken from earlier byte");
    a_count_capture: assert property (
        take && (state_q == uad_pkg::UAD_COUNT) && !byte_last_in
        |=> (left_q == $past(byte_in)) && (state_q == uad_pkg::UAD_BASE_HI))
        else $error("Character count not captured from second byte");
    a_half_base_form: assert property (
        take && (state_q == uad_pkg::UAD_BASE_HI) && half_q
        |=> (base_q[15] == 1'b0) && (base_q[6:0] == 7'h00)
            && (base_q[14:7] == $past(byte_in)))
        else $error("Half-page base pointer badly formed");
    a_dflt_passthru: assert property (
        take && emit_char && !top_set
        |-> emit && (emit_data == {9'h000, byte_in[6:0]}))
        else $error("Default-alphabet byte not emitted as 7-bit character");
    a_offset_add: assert property (
        take && emit_char && top_set
        |-> emit && (emit_data == base_q + {9'h000, byte_in[6:0]}))
        else $error("Offset character not added to base pointer");
    a_full_base_form: assert property (
        take && (state_q == uad_pkg::UAD_BASE_HI) && !half_q && !byte_last_in ##1
        take && (state_q == uad_pkg::UAD_BASE_LO)
        |=> (base_q == {$past(byte_in, 2), $past(byte_in)}))
        else $error("Full base pointer not built from two bytes");
    a_ff_in_count: assert property (
        take && emit_char && (byte_in == uad_pkg::PAD_BYTE)
        |-> emit && (emit_data == base_q + 16'h007F))
        else $error("FF inside count treated as padding");
    a_plain_passthru: assert property (
        take && (state_q == uad_pkg::UAD_PASS) && (byte_in != uad_pkg::PAD_BYTE)
        |-> emit && (emit_data[15:7] == 9'h000))
        else $error("Unmarked record byte not passed through");
    a_count_stop: assert property (
        take && emit_char && (left_q == 8'h01) && !byte_last_in
        |=> done_out && (state_q != uad_pkg::UAD_CHARS) ##1 !done_out)
        else $error("Decoder did not stop at declared count");
endmodule
`default_nettype wire

// *** uad_pkg.sv ***
`default_nettype none
package uad_pkg;
    // Widths of the byte stream and the code point stream, and the buffer depth
    localparam int          BYTE_W      = 8;
    localparam int          CP_W        = 16;
    localparam int          BUF_DEPTH   = 2;
    // Leading bytes that select a 16-bit scheme
    localparam logic [7:0]  LEAD_PAIRS  = 8'h80;
    localparam logic [7:0]  LEAD_HALF8  = 8'h81;
    localparam logic [7:0]  LEAD_HALF16 = 8'h82;
    // Padding values
    localparam logic [7:0]  PAD_BYTE    = 8'hFF;
    localparam logic [15:0] PAD_PAIR    = 16'hFFFF;
    // Bit positions inside a character byte
    localparam int          SEL_BIT     = 7;
    localparam int          HALF_LSB    = 7;
    // Values after reset
    localparam logic [15:0] BASE_RST    = 16'h0000;
    localparam logic [7:0]  COUNT_RST   = 8'h00;
    localparam logic [7:0]  HI_RST      = 8'h00;

    typedef enum logic [3:0] {
        UAD_IDLE,
        UAD_COUNT,
        UAD_BASE_HI,
        UAD_BASE_LO,
        UAD_CHARS,
        UAD_PAIR_HI,
        UAD_PAIR_LO,
        UAD_PASS,
        UAD_DRAIN
    } uad_state_e;
endpackage
`default_nettype wire

// *** uad_skid_buf.sv ***
`default_nettype none
module uad_skid_buf #(
    parameter int WIDTH = uad_pkg::CP_W,
    parameter int DEPTH = uad_pkg::BUF_DEPTH
) (
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_IX = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    wire              push;
    wire              pop;

    // Handshakes and honest full / empty
    assign in_ready_out  = (cnt_q != FULL_CNT);
    assign out_valid_out = (cnt_q != '0);
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;
    assign out_data_out  = mem_q[rd_q];

    // Storage array, written only on a push
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end

    // Pointers and fill count
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == LAST_IX) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == LAST_IX) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    a_buf_fill_bound: assert property (cnt_q <= FULL_CNT)
        else $error("Buffer fill count above depth");
endmodule
`default_nettype wire

// *** ucs2_alpha_field_decoder_tb.sv ***
`default_nettype none
// Bench: a byte level model is compared with the decoder at every result
module ucs2_alpha_field_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic [7:0]  byte_in;
    logic        byte_valid_in, byte_last_in, byte_ready_out;
    logic [15:0] cp_out;
    logic        cp_valid_out, done_out;
    logic        cp_ready_in = 1'b0;
    int          n_mismatch = 0, checks = 0, pos = 0, cnt = 0, nemit = 0, k = 0;
    logic        fin = 1'b0, exp_done = 1'b0, hold = 1'b0, stall = 1'b0;
    logic [7:0]  lead = 8'h00, hi = 8'h00;
    logic [15:0] base = 16'h0000;
    logic [15:0] exp_q[$];
    logic [7:0]  r[$];
    logic [31:0] seed = 32'hA32E;

    always #20 clk_in = ~clk_in;

    uad_byte_src SRC (.clk_in(clk_in), .ready_in(byte_ready_out), .stall_in(stall),
        .byte_out(byte_in), .valid_out(byte_valid_in), .last_out(byte_last_in));
    uad_decoder DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .byte_in(byte_in),
        .byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in),
        .byte_ready_out(byte_ready_out), .cp_out(cp_out), .cp_valid_out(cp_valid_out),
        .cp_ready_in(cp_ready_in), .done_out(done_out));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Model step for one taken byte
    task automatic step(input logic [7:0] b, input logic l);
        logic [15:0] c;
        int          h;
        c = b[7] ? base + {9'h000, b[6:0]} : {9'h000, b[6:0]};
        if (pos == 0)
            lead = b;
        h = (lead == 8'h81) ? 2 : (lead == 8'h82) ? 3 : 0;
        if (fin)
            c = 16'h0000;
        else if (!(lead inside {8'h80, 8'h81, 8'h82}))
        begin
            if (b != 8'hFF)
                exp_q.push_back({9'h000, b[6:0]});
        end
        else if (pos == 0)
            c = 16'h0000;
        else if (lead == 8'h80)
        begin
            if (pos[0])
                hi = b;
            else if ({hi, b} != 16'hFFFF)
                exp_q.push_back({hi, b});
        end
        else if (pos == 1)
            cnt = b;
        else if (h == 2 && pos == 2)
            base = {1'b0, b, 7'h00};
        else if (h == 3 && pos == 2)
            base[15:8] = b;
        else if (h == 3 && pos == 3)
            base[7:0] = b;
        else if (nemit < cnt)
        begin
            exp_q.push_back(c);
            nemit++;
        end
        if (!fin && (l || (h > 0 && pos >= h && nemit == cnt)))
        begin
            fin = 1'b1;
            exp_done = 1'b1;
        end
        pos++;
        if (l)
        begin
            pos = 0;
            fin = 1'b0;
            nemit = 0;
        end
    endtask

    // Monitor: results and done pulses against the model
    always @(posedge clk_in)
    begin
        if (rst_b_in)
        begin
            check("done_out", {15'h0000, exp_done}, {15'h0000, done_out});
            exp_done = 1'b0;
            if (cp_valid_out && cp_ready_in)
                check("cp_out", (exp_q.size() > 0) ? exp_q.pop_front() : 16'hDEAD, cp_out);
            if (byte_valid_in && byte_ready_out)
                step(byte_in, byte_last_in);
        end
    end

    // Random receiver stalls and source gaps
    always @(posedge clk_in)
    begin
        #1;
        seed = xs(seed);
        cp_ready_in = !hold && (seed[1:0] != 2'b00);
        stall = (seed[5:4] == 2'b00);
    end

    task automatic push();
        foreach (r[i])
            SRC.q.push_back({i == r.size() - 1, r[i]});
    endtask

    task automatic finish_rec(input string nm);
        int i;
        for (i = 0; i < 3000 && (SRC.q.size() > 0 || byte_valid_in || exp_q.size() > 0); i++)
            @(posedge clk_in);
        if (i == 3000)
        begin
            n_mismatch++;
            $display("CHECK FAILED drain expected empty seen busy");
        end
        repeat (3) @(posedge clk_in);
        #1;
        check("idle cp_valid_out", 16'h0000, {15'h0000, cp_valid_out});
        $display("test %s done", nm);
    endtask

    task automatic send(input string nm);
        push();
        finish_rec(nm);
    endtask

    // Watchdog
    initial
    begin
        repeat (30000) @(posedge clk_in);
        n_mismatch++;
        $display("watchdog expired");
        finish_test();
    end

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk_in);
        #1;
        check("rst byte_ready_out", 16'h0001, {15'h0000, byte_ready_out});
        check("rst cp_valid_out", 16'h0000, {15'h0000, cp_valid_out});
        rst_b_in = 1'b1;
        r = '{8'h80, 8'h00, 8'h41, 8'h04, 8'h2D, 8'hFF, 8'hFF};
        send("pairs padded");
        r = '{8'h80, 8'h12, 8'h34, 8'hFF};
        send("pairs odd tail");
        r = '{8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h31, 8'hFF, 8'hFF};
        send("half page base8");
        r = '{8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31};
        send("half page base16");
        r = '{8'h81, 8'h00, 8'h20, 8'h41};
        send("count zero");
        r = '{8'h82};
        send("lead only");
        r = '{8'h41, 8'hFF, 8'h7A, 8'hC1};
        send("pass through");
        for (k = 0; k < 24; k++)
        begin
            seed = xs(seed);
            r = '{k[1:0] == 2'd3 ? 8'h41 : {6'h20, k[1:0]}};
            r.push_back({4'h0, seed[3:0] % 4'd12});
            repeat (seed[7:4] % 4'd13) r.push_back(seed[15:8] ^ 8'(r.size() * 37));
            // Pair records of even length end in the unusable pad byte
            if (r[0] == 8'h80 && r.size() % 2 == 0)
                r[r.size() - 1] = 8'hFF;
            push();
            if (k[0])
                finish_rec("random back to back");
        end
        hold = 1'b1;
        r = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35};
        push();
        repeat (20) @(posedge clk_in);
        #1;
        check("full byte_ready_out", 16'h0000, {15'h0000, byte_ready_out});
        check("full cp_valid_out", 16'h0001, {15'h0000, cp_valid_out});
        hold = 1'b0;
        finish_rec("full buffer");
        finish_test();
    end
endmodule
`default_nettype wire
